//--- inc/ets_pkg.sv
package ets_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DIV_W   = 16;
  localparam int unsigned CNT_W   = 32;
  localparam int unsigned FLAG_W  = 2;
  localparam int unsigned DLY_W   = 2;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_TIMER_MODE_CONTROL  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ALARM_COMPARE_VALUE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CURRENT_COUNT_VALUE = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_EVENT_FLAGS         = 12'h00C;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned MODE_DIV_LSB   = 0;
  localparam int unsigned MODE_ALM_IEN   = 16;
  localparam int unsigned MODE_INC_IEN   = 17;
  localparam int unsigned MODE_RESTART   = 18;
  localparam int unsigned FLAG_ALARM     = 0;
  localparam int unsigned FLAG_INCREMENT = 1;

  // ------------------------------------------------------------------
  // Reset values and constants
  // ------------------------------------------------------------------
  localparam logic [DIV_W-1:0]  RST_DIVISOR = 16'h8000;
  localparam logic [CNT_W-1:0]  RST_ALARM   = 32'hFFFF_FFFF;
  localparam logic [CNT_W-1:0]  RST_COUNT   = 32'h0000_0000;
  localparam logic [FLAG_W-1:0] RST_FLAGS   = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 32'h0000_0001;
  localparam logic [DIV_W-1:0]  DIV_ONE     = 16'h0001;
  localparam logic [DIV_W-1:0]  DIV_ZERO    = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 32'h0000_0000;

  // Slow-clock edges between request and effect
  localparam logic [DLY_W-1:0]  SLOW_DELAY  = 2'h2;
  localparam logic [DLY_W-1:0]  DLY_ZERO    = 2'h0;
  localparam logic [DLY_W-1:0]  DLY_ONE     = 2'h1;

endpackage

//--- src/ets_sync.sv
`timescale 1ns/100ps

module ets_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ------------------------------------------------------------------
  // Two-stage synchroniser
  // ------------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // ets_sync

//--- src/ets_prescaler.sv
`timescale 1ns/100ps

module ets_prescaler #(
  parameter int unsigned WIDTH = ets_pkg::DIV_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             slow_edge,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  tick
);

  import ets_pkg::*;

  // ------------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------------
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] last;

  // Zero wraps to all ones: a full 2^WIDTH period
  assign last = divisor - WIDTH'(1);

  // Compare with >= so a shrunk divisor does not run a full wrap
  assign tick = slow_edge && !load && (cnt_q >= last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= '0;
    end else if (slow_edge) begin
      if (cnt_q >= last) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + WIDTH'(1);
      end
    end
  end

endmodule // ets_prescaler

//--- src/ets_elapsed_time_counter.sv
`timescale 1ns/100ps


module ets_elapsed_time_counter #(
  parameter int unsigned ADDR_WIDTH = ets_pkg::ADDR_W
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_WIDTH-1:0]     paddr,
  input  wire logic [ets_pkg::DATA_W-1:0] pwdata,
  output logic      [ets_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      slow_clock,
  output logic                           irq
);

  import ets_pkg::*;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function automatic logic reg_hit(
    input logic [ADDR_WIDTH-1:0] addr,
    input logic [ADDR_W-1:0]     offset
  );
    reg_hit = (addr == ADDR_WIDTH'(offset));
  endfunction

  // ------------------------------------------------------------------
  // Slow-domain wait
  // ------------------------------------------------------------------
  // True on the second synced slow edge after the request was taken
  function automatic logic wait_over(
    input logic             pend,
    input logic [DLY_W-1:0] dly,
    input logic             slow_edge
  );
    wait_over = pend && slow_edge && (dly == SLOW_DELAY - DLY_ONE);
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [DIV_W-1:0]  divisor_q;
  logic              alm_ien_q;
  logic              inc_ien_q;
  logic [CNT_W-1:0]  alarm_q;
  logic [CNT_W-1:0]  count_q;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;

  logic              rst_pend_q;
  logic [DLY_W-1:0]  rst_dly_q;
  logic              clr_pend_q;
  logic [DLY_W-1:0]  clr_dly_q;

  logic              slow_sync;
  logic              slow_prev_q;
  logic              slow_rise;

  logic              pready_q;
  logic              pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic              irq_q;

  // ------------------------------------------------------------------
  // Bus phase decode
  // ------------------------------------------------------------------
  logic access;
  logic first_acc;
  logic done;
  logic hit_mode;
  logic hit_alarm;
  logic hit_count;
  logic hit_flags;
  logic mapped;
  logic wr_done;
  logic rd_done;

  assign access    = psel && penable;
  assign first_acc = access && !pready_q;
  assign done      = access && pready_q;
  assign hit_mode  = reg_hit(paddr, OFF_TIMER_MODE_CONTROL);
  assign hit_alarm = reg_hit(paddr, OFF_ALARM_COMPARE_VALUE);
  assign hit_count = reg_hit(paddr, OFF_CURRENT_COUNT_VALUE);
  assign hit_flags = reg_hit(paddr, OFF_EVENT_FLAGS);
  assign mapped    = hit_mode || hit_alarm || hit_count || hit_flags;
  assign wr_done   = done && pwrite && mapped;
  assign rd_done   = done && !pwrite && mapped;

  // ------------------------------------------------------------------
  // Slow clock edge detect
  // ------------------------------------------------------------------
  ets_sync #(
    .WIDTH (1)
  ) u_slow_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (slow_clock),
    .q       (slow_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= slow_sync;
    end
  end

  // A slow clock high at reset release counts as one edge
  assign slow_rise = slow_sync && !slow_prev_q;

  // ------------------------------------------------------------------
  // Delayed restart
  // ------------------------------------------------------------------
  logic restart_req;
  logic restart_fire;

  assign restart_req  = wr_done && hit_mode && pwdata[MODE_RESTART];
  assign restart_fire = wait_over(rst_pend_q, rst_dly_q, slow_rise);

  // A newer restart write starts the wait over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pend_q <= 1'b0;
      rst_dly_q  <= DLY_ZERO;
    end else if (restart_req) begin
      rst_pend_q <= 1'b1;
      rst_dly_q  <= DLY_ZERO;
    end else if (restart_fire) begin
      rst_pend_q <= 1'b0;
      rst_dly_q  <= DLY_ZERO;
    end else if (rst_pend_q && slow_rise) begin
      rst_dly_q  <= rst_dly_q + DLY_ONE;
    end
  end

  // ------------------------------------------------------------------
  // Delayed flag clear
  // ------------------------------------------------------------------
  logic clear_req;
  logic clear_fire;

  assign clear_req  = rd_done && hit_flags;
  assign clear_fire = wait_over(clr_pend_q, clr_dly_q, slow_rise);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pend_q <= 1'b0;
      clr_dly_q  <= DLY_ZERO;
    end else if (clear_req) begin
      clr_pend_q <= 1'b1;
      clr_dly_q  <= DLY_ZERO;
    end else if (clear_fire) begin
      clr_pend_q <= 1'b0;
      clr_dly_q  <= DLY_ZERO;
    end else if (clr_pend_q && slow_rise) begin
      clr_dly_q  <= clr_dly_q + DLY_ONE;
    end
  end

  // ------------------------------------------------------------------
  // Prescaler and counter
  // ------------------------------------------------------------------
  logic             tick;
  logic [CNT_W-1:0] count_next;

  ets_prescaler #(
    .WIDTH (DIV_W)
  ) u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .slow_edge (slow_rise),
    .load      (restart_fire),
    .divisor   (divisor_q),
    .tick      (tick)
  );

  // Plain 32-bit add rolls all ones over to zero
  assign count_next = count_q + CNT_ONE;

  // Restart outranks a tick landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= RST_COUNT;
    end else if (restart_fire) begin
      count_q <= RST_COUNT;
    end else if (tick) begin
      count_q <= count_next;
    end
  end

  // ------------------------------------------------------------------
  // Mode and alarm registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_q <= RST_DIVISOR;
      alm_ien_q <= 1'b0;
      inc_ien_q <= 1'b0;
    end else if (wr_done && hit_mode) begin
      divisor_q <= pwdata[MODE_DIV_LSB +: DIV_W];
      alm_ien_q <= pwdata[MODE_ALM_IEN];
      inc_ien_q <= pwdata[MODE_INC_IEN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= RST_ALARM;
    end else if (wr_done && hit_alarm) begin
      alarm_q <= pwdata;
    end
  end

  // ------------------------------------------------------------------
  // Event flags
  // ------------------------------------------------------------------
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;

  // Match checked only on an advance, so the reset alarm of all ones
  // does not fire against the reset count of zero
  always_comb begin
    flag_set                 = RST_FLAGS;
    flag_set[FLAG_ALARM]     = tick && !restart_fire
                               && (count_next == alarm_q + CNT_ONE);
    flag_set[FLAG_INCREMENT] = tick && !restart_fire;
  end

  // Read clear after the slow delay, plus write-one-to-clear
  always_comb begin
    flag_clr = RST_FLAGS;
    if (clear_fire) begin
      flag_clr = ~RST_FLAGS;
    end
    if (wr_done && hit_flags) begin
      flag_clr = flag_clr | pwdata[FLAG_W-1:0];
    end
  end

  // New event wins over a clear in the same cycle
  assign flags_d = (flags_q & ~flag_clr) | flag_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------------
  // Registered so irq is a flop output, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (flags_q[FLAG_ALARM] && alm_ien_q)
               || (flags_q[FLAG_INCREMENT] && inc_ien_q);
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = DATA_ZERO;
    if (hit_mode) begin
      rd_word[MODE_DIV_LSB +: DIV_W] = divisor_q;
      rd_word[MODE_ALM_IEN]          = alm_ien_q;
      rd_word[MODE_INC_IEN]          = inc_ien_q;
    end else if (hit_alarm) begin
      rd_word = alarm_q;
    end else if (hit_count) begin
      rd_word = count_q;
    end else if (hit_flags) begin
      rd_word[FLAG_W-1:0] = flags_q;
    end
  end

  // ------------------------------------------------------------------
  // APB response: one wait state, data captured before completion
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= first_acc;
    end
  end

  // Unmapped offsets answer with an error and zero read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (first_acc) begin
      pslverr_q <= !mapped;
    end else if (done) begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= DATA_ZERO;
    end else if (first_acc && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

endmodule // ets_elapsed_time_counter

//--- verif/ets_asserts.sv
`timescale 1ns/100ps

module ets_asserts #(
  parameter int unsigned ADDR_WIDTH = 12
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ADDR_WIDTH-1:0]       paddr,
  input wire logic [ets_pkg::DATA_W-1:0]  pwdata,
  input wire logic [ets_pkg::DATA_W-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        slow_clock,
  input wire logic                        irq
);
  import ets_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic rd_flags;
  logic rd_mode;
  logic mapped;
  logic en_seen_q;
  assign rd_flags = pready && !pwrite && (paddr == OFF_EVENT_FLAGS);
  assign rd_mode  = pready && !pwrite && (paddr == OFF_TIMER_MODE_CONTROL);
  assign mapped   = paddr inside {OFF_TIMER_MODE_CONTROL, OFF_ALARM_COMPARE_VALUE,
                                  OFF_CURRENT_COUNT_VALUE, OFF_EVENT_FLAGS};

  // Sticky: once any enable was written, irq may legally rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen_q <= 1'b0;
    end else if (pready && pwrite && (paddr == OFF_TIMER_MODE_CONTROL)
                 && (pwdata[17:16] != 2'h0)) begin
      en_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late after access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_err_rdata_zero: assert property (pready && pslverr && !pwrite |-> prdata == DATA_ZERO)
    else $error("read data not zero on error");
  a_flags_layout: assert property (rd_flags |-> prdata[31:2] == 30'h0)
    else $error("flag read has bits above bit 1");
  a_mode_layout: assert property (rd_mode |-> prdata[31:18] == 14'h0)
    else $error("mode read shows restart or upper bits");
  a_irq_masked: assert property (!en_seen_q |-> !irq)
    else $error("irq with no enable ever written");
  a_irq_holds_read: assert property (rd_flags && irq |=> irq [*2])
    else $error("irq dropped right after flag read");

  c_read_irq: cover property (rd_flags && irq);
  c_error: cover property (pready && pslverr);
  c_restart: cover property (pready && pwrite && (paddr == OFF_TIMER_MODE_CONTROL)
                             && pwdata[MODE_RESTART]);
endmodule // ets_asserts

bind ets_elapsed_time_counter ets_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .slow_clock(slow_clock), .irq(irq)
);

//--- verif/tb_top.sv
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end

module tb_top;
  import ets_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              slow_clock = 1'b0;
  logic              irq;
  logic [2:0]        sdiv = 3'h0;
  int                fail_count = 0;
  int                n_tests = 0;
  int                cyc = 0;
  localparam int     SLOW_PER = 8;
  logic [31:0]       rv;
  logic              re;

  ets_elapsed_time_counter #(.ADDR_WIDTH(12)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clock(slow_clock), .irq(irq)
  );

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Slow clock: 8 pclk period, phase unrelated to bus traffic
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    sdiv <= sdiv + 3'h1;
    slow_clock <= sdiv[2];
  end

  // Ceiling well above the thousand or so cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the bench timeout ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wait_count(input logic [31:0] v);
    int n;
    n = 0;
    do begin
      rd(OFF_CURRENT_COUNT_VALUE);
      n++;
    end while (rv !== v && n < 200);
    `CHK("count reached", v, rv)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_TIMER_MODE_CONTROL);
    `CHK("mode reset", 32'h0000_8000, rv)
    rd(OFF_ALARM_COMPARE_VALUE);
    `CHK("alarm reset", 32'hFFFF_FFFF, rv)
    rd(OFF_EVENT_FLAGS);
    `CHK("flags reset", 32'h0000_0000, rv)
    wr(OFF_CURRENT_COUNT_VALUE, 32'h1234_5678);
    rd(OFF_CURRENT_COUNT_VALUE);
    `CHK("count read only", 32'h0000_0000, rv)
    `CHK("mapped no error", 1'b0, re)
    rd(12'h010);
    `CHK("unmapped error", 1'b1, re)
    `CHK("unmapped data", 32'h0000_0000, rv)
    `CHK("irq idle", 1'b0, irq)
    $display("test reset done");
  endtask

  task automatic t_restart();
    wr(OFF_TIMER_MODE_CONTROL, 32'h0004_0001);
    repeat (100) @(posedge pclk);
    wr(OFF_TIMER_MODE_CONTROL, 32'h0004_0004);
    rd(OFF_CURRENT_COUNT_VALUE);
    `CHK("count before restart lands", 1'b1, rv != 32'h0000_0000)
    repeat (20) @(posedge pclk);
    rd(OFF_CURRENT_COUNT_VALUE);
    `CHK("count after restart", 32'h0000_0000, rv)
    rd(OFF_CURRENT_COUNT_VALUE);
    `CHK("count reread agrees", 32'h0000_0000, rv)
    rd(OFF_TIMER_MODE_CONTROL);
    `CHK("restart bit reads 0", 32'h0000_0004, rv)
    $display("test restart done");
  endtask

  task automatic t_rate();
    logic [31:0] a;
    int          d;
    for (d = 1; d <= 4; d++) begin
      wr(OFF_TIMER_MODE_CONTROL, 32'h0004_0000 | 32'(d));
      repeat (30) @(posedge pclk);
      rd(OFF_CURRENT_COUNT_VALUE);
      a = rv;
      // Capture-to-capture gap of exactly five prescaler periods
      repeat (5 * d * SLOW_PER - 4) @(posedge pclk);
      rd(OFF_CURRENT_COUNT_VALUE);
      `CHK("increments per window", 32'h0000_0005, rv - a)
    end
    $display("test rate done");
  endtask

  task automatic t_alarm();
    wr(OFF_ALARM_COMPARE_VALUE, 32'h0000_0002);
    wr(OFF_TIMER_MODE_CONTROL, 32'h0005_0004);
    wait_count(32'h0000_0002);
    rd(OFF_EVENT_FLAGS);
    `CHK("flags before alarm", 32'h0000_0002, rv)
    `CHK("irq no alarm yet", 1'b0, irq)
    wait_count(32'h0000_0003);
    rd(OFF_EVENT_FLAGS);
    `CHK("flags at alarm", 32'h0000_0003, rv)
    `CHK("irq on alarm", 1'b1, irq)
    // Clear lands within 16 cycles; the next tick comes after the next read
    repeat (18) @(posedge pclk);
    `CHK("irq after clear", 1'b0, irq)
    rd(OFF_EVENT_FLAGS);
    `CHK("flags cleared", 32'h0000_0000, rv)
    $display("test alarm done");
  endtask

  task automatic t_inc_irq();
    wr(OFF_TIMER_MODE_CONTROL, 32'h0002_0004);
    repeat (80) @(posedge pclk);
    `CHK("irq on increment", 1'b1, irq)
    wr(OFF_TIMER_MODE_CONTROL, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    `CHK("irq masked", 1'b0, irq)
    // Long divisor so no tick can race the write-one clear
    wr(OFF_TIMER_MODE_CONTROL, 32'h0006_0100);
    repeat (24) @(posedge pclk);
    `CHK("irq before write clear", 1'b1, irq)
    wr(OFF_EVENT_FLAGS, 32'h0000_0003);
    rd(OFF_EVENT_FLAGS);
    `CHK("flags write-one clear", 32'h0000_0000, rv)
    `CHK("irq after write clear", 1'b0, irq)
    $display("test increment irq done");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_restart();
    t_rate();
    t_alarm();
    t_inc_irq();
    conclude();
  end
endmodule // tb_top
